// ===== verilog/ata_cmd_cfg.svh
// Constants for the idle, geometry and read-buffer command logic
`ifndef ATA_CMD_CFG_SVH
`define ATA_CMD_CFG_SVH
// ============================================================
// Opcodes
`define OPC_IDLE_IMM     8'hE1
`define OPC_IDLE_IMM_ALT 8'h95
`define OPC_INIT_PARAM   8'h91
`define OPC_READ_BUF     8'hE4
// ============================================================
// Task-file register addresses
`define TF_DATA    3'h0
`define TF_ERROR   3'h1
`define TF_SECCNT  3'h2
`define TF_DEVHEAD 3'h6
`define TF_STATUS  3'h7
// ============================================================
// Status and error bit positions
`define ST_BSY 7
`define ST_RDY 6
`define ST_DF  5
`define ST_DSC 4
`define ST_DRQ 3
`define ST_ERR 0
`define ER_ABT 2
// ============================================================
// Geometry, buffer and feature values
`define DEF_SPT        8'h3F
`define DEF_HEADS_M1   4'hF
`define SECTOR_WORDS   9'h100
`define FEAT_DEFAULTS  8'hCC
`define FIFO_WIDTH     16
`define FIFO_DEPTH     32
`endif

// ===== verilog/ata_cmd_pkg.sv
// Types shared by the command logic
package ata_cmd_pkg;
	// ============================================================
	// Command sequencer states
	typedef enum logic [1:0] {CS_READY, CS_SPIN, CS_PUMP, CS_DRAIN} cmd_state_t;
	// Power mode
	typedef enum logic {PM_STANDBY, PM_IDLE} power_mode_t;
	// One task-file access from the host controller
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [2:0]  addr;
		logic [15:0] wdata;
	} tf_req_t;
	// Logical geometry
	typedef struct packed {
		logic [3:0] heads_m1;
		logic [7:0] spt;
	} geom_t;
endpackage : ata_cmd_pkg

// ===== verilog/sector_fifo.sv
// Parameterised word FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module sector_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 32
) (
	input  wire logic             sys_clk,
	input  wire logic             rst_n,
	input  wire logic             flush,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);
	localparam int AW = $clog2(DEPTH);
	// ============================================================
	// Storage and pointers, one extra bit tells full from empty
	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW:0]      wp_r;
	logic [AW:0]      rp_r;
	logic             push;
	logic             pop;

	assign in_ready  = (wp_r - rp_r) != (AW+1)'(DEPTH);
	assign out_valid = wp_r != rp_r;
	assign out_data  = mem_r[rp_r[AW-1:0]];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	// Pointers; flush empties at once
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			wp_r <= '0;
			rp_r <= '0;
		end else if (flush) begin
			wp_r <= '0;
			rp_r <= '0;
		end else begin
			if (push) wp_r <= wp_r + 1'b1;
			if (pop) rp_r <= rp_r + 1'b1;
		end
	end

	// Data words, no reset needed
	always_ff @(posedge sys_clk) begin
		if (push) mem_r[wp_r[AW-1:0]] <= in_data;
	end

	// Full refuses further words
	chk_fifo_full_stall: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(wp_r - rp_r) == (AW+1)'(DEPTH) |-> !in_ready)
		else $error("fifo accepts while full");

	// Pointer distance never passes the depth, or words would be lost
	chk_fifo_no_overrun: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(wp_r - rp_r) <= (AW+1)'(DEPTH))
		else $error("fifo holds more than its depth");
endmodule : sector_fifo
`default_nettype wire

// ===== verilog/standby_timer.sv
// Automatic power-down interval counter
`timescale 1ns/1ps
`default_nettype none
module standby_timer (
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	input  wire logic        enable,
	input  wire logic [31:0] limit,
	input  wire logic        host_access,
	output logic             expired_r
);
	// ============================================================
	// Interval count, restarted by any host access
	logic [31:0] count_r;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			count_r   <= '0;
			expired_r <= 1'b0;
		end else if (!enable || host_access || limit == 32'h0) begin
			count_r   <= '0;
			expired_r <= 1'b0;
		end else if (count_r == limit - 32'h1) begin
			count_r   <= '0;
			expired_r <= 1'b1;
		end else begin
			count_r   <= count_r + 32'h1;
			expired_r <= 1'b0;
		end
	end

	// Expiry only after a quiet full interval
	chk_standby_expiry: assert property (@(posedge sys_clk) disable iff (!rst_n)
		host_access |=> !expired_r)
		else $error("standby expired right after access");
endmodule : standby_timer
`default_nettype wire

// ===== verilog/ata_cmd_core.sv
// Idle immediate, geometry set-up and read-buffer command logic
//
// Function
// - Idle immediate enters Idle, no timeout taken
// - Spin up on Idle unless already spinning
// - Idle keeps spinning, commands accepted immediately
// - Idle immediate leaves standby timer untouched
// - Geometry from sector count and head field
// - Identify words show current geometry
// - Geometry kept until command, power, reset
// - Zero sectors per track means zero
// - Heads minus one accepts 0 to 15
// - Read buffer sends exactly one sector
// - Sector moves as 16-bit data words
// - Sector comes from last written buffer
// - Buffer contents may change by media traffic
// - Timer expiry enters Standby, access restarts
`timescale 1ns/1ps
`default_nettype none
`include "ata_cmd_cfg.svh"
module ata_cmd_core
	import ata_cmd_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	input  wire tf_req_t     tf_req,
	output logic [15:0]      tf_rdata_r,
	output logic             cmd_done_r,
	input  wire logic        buf_wr,
	input  wire logic [7:0]  buf_waddr,
	input  wire logic [15:0] buf_wdata,
	input  wire logic        media_at_speed,
	input  wire logic        soft_reset,
	input  wire logic [7:0]  feature_reset_sel,
	input  wire logic        standby_en,
	input  wire logic [31:0] standby_limit,
	output logic             spin_req_r,
	output logic             power_idle_r,
	output logic [15:0]      id_heads_word_r,
	output logic [15:0]      id_spt_word_r
);
	// ============================================================
	// State
	cmd_state_t  state_r;        // Sequencer
	power_mode_t mode_r;         // Idle or standby
	geom_t       geom_r;         // Current logical geometry
	logic [7:0]  seccnt_r;       // Sector count field
	logic [7:0]  devhead_r;      // Device/head field
	logic        err_abt_r;      // Abort bit of the error register
	logic        err_sum_r;      // Error summary bit of status
	logic        buf_filled_r;   // A word has been written to the buffer
	logic [8:0]  push_cnt_r;     // Words handed to the FIFO
	logic [15:0] sector_r [256]; // Sector buffer
	logic        expired;        // Standby interval ran out

	// ============================================================
	// Decoding helpers
	logic        cmd_wr;      // Command register written while ready
	logic        is_idle;     // Idle immediate opcode
	logic        is_init;     // Geometry opcode
	logic        is_rbuf;     // Read buffer opcode
	logic        host_access; // Any task-file access
	logic        do_defaults; // Soft reset with defaults selected
	logic        fifo_in_ready;
	logic        fifo_out_valid;
	logic [15:0] fifo_out_data;
	logic        pump_push;
	logic        data_pop;
	logic        xfer;
	logic        transfer_request_flag;
	logic        bsy;
	logic [7:0]  status;

	// Idle immediate carries two opcodes
	function automatic logic idle_opc(input logic [7:0] op);
		return op == `OPC_IDLE_IMM || op == `OPC_IDLE_IMM_ALT;
	endfunction : idle_opc

	assign cmd_wr      = tf_req.wr && tf_req.addr == `TF_STATUS && state_r == CS_READY;
	assign is_idle     = idle_opc(tf_req.wdata[7:0]);
	assign is_init     = tf_req.wdata[7:0] == `OPC_INIT_PARAM;
	assign is_rbuf     = tf_req.wdata[7:0] == `OPC_READ_BUF;
	assign host_access = tf_req.wr || tf_req.rd;
	assign do_defaults = soft_reset && feature_reset_sel == `FEAT_DEFAULTS;
	assign xfer        = state_r == CS_PUMP || state_r == CS_DRAIN;
	assign transfer_request_flag         = xfer && fifo_out_valid;
	assign bsy         = state_r == CS_SPIN || (xfer && !fifo_out_valid);
	assign pump_push   = state_r == CS_PUMP && fifo_in_ready;
	assign data_pop    = tf_req.rd && tf_req.addr == `TF_DATA && transfer_request_flag;

	// Status: fault stays clear, seek complete while spinning
	assign status = {bsy, !bsy, 1'b0, media_at_speed, transfer_request_flag, 2'b00, err_sum_r};

	// ============================================================
	// Parameter fields written by the host
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			seccnt_r  <= 8'h00;
			devhead_r <= 8'h00;
		end else if (tf_req.wr && state_r == CS_READY) begin
			if (tf_req.addr == `TF_SECCNT) seccnt_r <= tf_req.wdata[7:0];
			if (tf_req.addr == `TF_DEVHEAD) devhead_r <= tf_req.wdata[7:0];
		end
	end

	// ============================================================
	// Command sequencer
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r    <= CS_READY;
			cmd_done_r <= 1'b0;
			err_abt_r  <= 1'b0;
			err_sum_r  <= 1'b0;
		end else if (soft_reset) begin
			// Reset drops any command in flight
			state_r    <= CS_READY;
			cmd_done_r <= 1'b0;
			err_abt_r  <= 1'b0;
			err_sum_r  <= 1'b0;
		end else begin
			cmd_done_r <= 1'b0;
			case (state_r)
				CS_READY: begin
					if (cmd_wr) begin
						err_abt_r <= 1'b0;
						err_sum_r <= 1'b0;
						if (is_idle && !media_at_speed) begin
							state_r <= CS_SPIN;
						end else if (is_idle || is_init) begin
							cmd_done_r <= 1'b1;
						end else if (is_rbuf && buf_filled_r) begin
							state_r <= CS_PUMP;
						end else begin
							// Unknown opcode, or nothing buffered yet
							err_abt_r  <= 1'b1;
							err_sum_r  <= 1'b1;
							cmd_done_r <= 1'b1;
						end
					end
				end
				CS_SPIN: begin
					// Busy until the motor reports speed
					if (media_at_speed) begin
						state_r    <= CS_READY;
						cmd_done_r <= 1'b1;
					end
				end
				CS_PUMP: begin
					if (pump_push && push_cnt_r == `SECTOR_WORDS - 9'h1) state_r <= CS_DRAIN;
				end
				CS_DRAIN: begin
					// Done when the host has taken the last word
					if (!fifo_out_valid) begin
						state_r    <= CS_READY;
						cmd_done_r <= 1'b1;
					end
				end
				default: state_r <= CS_READY;
			endcase
		end
	end

	// ============================================================
	// Power mode and spindle request
	// The standby interval is never written here, it comes only from the standby_limit input
	// Sector count is ignored here, so no stale timeout leaks into the timer
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_r     <= PM_STANDBY;
			spin_req_r <= 1'b0;
		end else if (cmd_wr && is_idle) begin
			mode_r     <= PM_IDLE;
			spin_req_r <= 1'b1;
		end else if (expired && state_r == CS_READY) begin
			mode_r     <= PM_STANDBY;
			spin_req_r <= 1'b0;
		end
	end

	// Idle flag for the outside
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) power_idle_r <= 1'b0;
		else power_idle_r <= (mode_r == PM_IDLE);
	end

	// ============================================================
	// Logical geometry; survives everything but these events
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			geom_r <= '{heads_m1: `DEF_HEADS_M1, spt: `DEF_SPT};
		end else if (cmd_wr && is_init) begin
			// Zero stays zero, every head value is legal
			geom_r.spt      <= seccnt_r;
			geom_r.heads_m1 <= devhead_r[3:0];
		end else if (do_defaults) begin
			geom_r <= '{heads_m1: `DEF_HEADS_M1, spt: `DEF_SPT};
		end
	end

	// Identify words for heads and sectors per track
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			id_heads_word_r <= 16'h0000;
			id_spt_word_r   <= 16'h0000;
		end else begin
			id_heads_word_r <= {11'h000, 5'(geom_r.heads_m1) + 5'h01};
			id_spt_word_r   <= {8'h00, geom_r.spt};
		end
	end

	// ============================================================
	// Sector buffer; media traffic may overwrite it at any time
	always_ff @(posedge sys_clk) begin
		if (buf_wr) sector_r[buf_waddr] <= buf_wdata;
	end

	// Remember that a buffer word was written
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) buf_filled_r <= 1'b0;
		else if (buf_wr) buf_filled_r <= 1'b1;
	end

	// Word counter of the outgoing sector
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) push_cnt_r <= 9'h000;
		else if (state_r == CS_READY) push_cnt_r <= 9'h000;
		else if (pump_push) push_cnt_r <= push_cnt_r + 9'h001;
	end

	// ============================================================
	// Read data; a data read during a data request pops one word
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			tf_rdata_r <= 16'h0000;
		end else if (tf_req.rd) begin
			case (tf_req.addr)
				`TF_DATA:    tf_rdata_r <= transfer_request_flag ? fifo_out_data : 16'h0000;
				`TF_ERROR:   tf_rdata_r <= {13'h0000, err_abt_r, 2'b00};
				`TF_SECCNT:  tf_rdata_r <= {8'h00, seccnt_r};
				`TF_DEVHEAD: tf_rdata_r <= {8'h00, devhead_r};
				`TF_STATUS:  tf_rdata_r <= {8'h00, status};
				default:     tf_rdata_r <= 16'h0000;
			endcase
		end
	end

	// ============================================================
	// Sub-blocks
	// FIFO decouples buffer reads from host pacing; soft reset flushes it
	sector_fifo #(
		.WIDTH(`FIFO_WIDTH),
		.DEPTH(`FIFO_DEPTH)
	) u_fifo (
		.sys_clk   (sys_clk),
		.rst_n     (rst_n),
		.flush     (soft_reset),
		.in_valid  (state_r == CS_PUMP),
		.in_ready  (fifo_in_ready),
		.in_data   (sector_r[push_cnt_r[7:0]]),
		.out_valid (fifo_out_valid),
		.out_ready (data_pop),
		.out_data  (fifo_out_data)
	);

	// Interval comes only from its own input, never from a command field
	standby_timer u_timer (
		.sys_clk     (sys_clk),
		.rst_n       (rst_n),
		.enable      (standby_en),
		.limit       (standby_limit),
		.host_access (host_access),
		.expired_r   (expired)
	);

	// ============================================================
	// Checks
	chk_idle_mode_entry: assert property (@(posedge sys_clk) disable iff (!rst_n)
		cmd_wr && is_idle && !soft_reset |=> mode_r == PM_IDLE ##1 power_idle_r)
		else $error("idle immediate did not enter idle");

	chk_spin_skip: assert property (@(posedge sys_clk) disable iff (!rst_n)
		cmd_wr && is_idle && media_at_speed && !soft_reset |=> cmd_done_r && state_r == CS_READY)
		else $error("spin-up not skipped");

	chk_idle_spinning: assert property (@(posedge sys_clk) disable iff (!rst_n)
		mode_r == PM_IDLE |-> spin_req_r)
		else $error("idle without spindle request");

	chk_geom_load: assert property (@(posedge sys_clk) disable iff (!rst_n)
		cmd_wr && is_init && !soft_reset |=> geom_r == {$past(devhead_r[3:0]), $past(seccnt_r)})
		else $error("geometry not loaded");

	chk_ident_words: assert property (@(posedge sys_clk) disable iff (!rst_n)
		cmd_wr && is_init && !soft_reset |=> ##1 id_spt_word_r == {8'h00, $past(seccnt_r, 2)})
		else $error("identify word stale");

	chk_geom_persist: assert property (@(posedge sys_clk) disable iff (!rst_n)
		!(cmd_wr && is_init) && !do_defaults |=> $stable(geom_r))
		else $error("geometry changed without cause");

	chk_sector_count: assert property (@(posedge sys_clk) disable iff (!rst_n)
		state_r == CS_PUMP && !soft_reset ##1 state_r == CS_DRAIN |-> push_cnt_r == `SECTOR_WORDS)
		else $error("sector length wrong");

	chk_abort_status: assert property (@(posedge sys_clk) disable iff (!rst_n)
		cmd_wr && is_rbuf && !buf_filled_r && !soft_reset |=> err_abt_r && err_sum_r && cmd_done_r)
		else $error("abort not reported");

	chk_done_once: assert property (@(posedge sys_clk) disable iff (!rst_n)
		cmd_done_r |-> state_r == CS_READY && !bsy ##1 !cmd_done_r)
		else $error("completion repeated or busy");

	// Idle from a stopped spindle waits busy with the spindle requested
	chk_spin_start: assert property (@(posedge sys_clk) disable iff (!rst_n)
		cmd_wr && is_idle && !media_at_speed && !soft_reset |=> state_r == CS_SPIN && spin_req_r)
		else $error("spin-up not started");

	// No completion while the motor is still below speed
	chk_spin_wait: assert property (@(posedge sys_clk) disable iff (!rst_n)
		state_r == CS_SPIN && !media_at_speed && !soft_reset |=> state_r == CS_SPIN && !cmd_done_r)
		else $error("spin wait left early");

	// A popped word is exactly the FIFO head of that cycle
	chk_drq_data_pop: assert property (@(posedge sys_clk) disable iff (!rst_n)
		data_pop |=> tf_rdata_r == $past(fifo_out_data))
		else $error("data word differs from fifo head");

	// Reads beyond the sector hand out nothing
	chk_empty_data_read: assert property (@(posedge sys_clk) disable iff (!rst_n)
		tf_req.rd && tf_req.addr == `TF_DATA && !transfer_request_flag |=> tf_rdata_r == 16'h0000)
		else $error("data read without request returned a word");

	// Defaults come back through the selected soft reset
	chk_defaults_restore: assert property (@(posedge sys_clk) disable iff (!rst_n)
		do_defaults && !(cmd_wr && is_init) |=> geom_r == {`DEF_HEADS_M1, `DEF_SPT})
		else $error("default geometry not restored");

	// An accepted command starts with a clean error report
	chk_error_cleared: assert property (@(posedge sys_clk) disable iff (!rst_n)
		cmd_wr && (is_idle || is_init) && !soft_reset |=> !err_abt_r && !err_sum_r)
		else $error("stale abort after good command");
endmodule : ata_cmd_core
`default_nettype wire

// ===== verif/host_model.sv
// Host task-file controller model issuing single-cycle register accesses
`timescale 1ns/1ps
`default_nettype none
module host_model
	import ata_cmd_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic [15:0] tf_rdata_r,
	output var tf_req_t      tf_req
);
	// ============================================================
	// Access strobes
	// Idle bus at time zero, no strobe raised
	initial tf_req = '0;

	// Write strobe launched after an edge, dropped after the next one
	task automatic tf_write(input logic [2:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		tf_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge sys_clk);
		// Released data shows the inverse so a stale value is never mistaken
		tf_req <= '{wr: 1'b0, rd: 1'b0, addr: a, wdata: ~d};
	endtask : tf_write

	// Read strobe; data is taken one cycle later, whole 16-bit word
	task automatic tf_read(input logic [2:0] a, output logic [15:0] d);
		@(posedge sys_clk);
		tf_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
		@(posedge sys_clk);
		tf_req <= '{wr: 1'b0, rd: 1'b0, addr: a, wdata: 16'hFFFF};
		#1;
		d = tf_rdata_r;
	endtask : tf_read
endmodule : host_model
`default_nettype wire

// ===== verif/ata_idle_geometry_buffer_cmds_tb_top.sv
// Self-checking bench for the idle, geometry and read-buffer commands
`timescale 1ns/1ps
`default_nettype none
`include "ata_cmd_cfg.svh"
module ata_idle_geometry_buffer_cmds_tb_top
	import ata_cmd_pkg::*;
;
	// ============================================================
	// Signals
	logic        sys_clk = 1'b0;        // 200 MHz clock
	logic        rst_n = 1'b0;          // Async reset, low active
	tf_req_t     tf_req;                // Host access, from the model
	logic [15:0] tf_rdata_r;            // Read data
	logic        cmd_done_r;            // Completion pulse
	logic        buf_wr = 1'b0;         // Buffer word write
	logic [7:0]  buf_waddr = 8'h00;     // Buffer word index
	logic [15:0] buf_wdata = 16'h0000;  // Buffer word
	logic        media_at_speed = 1'b0; // Spindle at speed
	logic        soft_reset = 1'b0;     // Soft reset pulse
	logic [7:0]  feature_reset_sel = 8'h66; // Keep geometry on soft reset
	logic        standby_en = 1'b0;     // Power-down timer enable
	logic [31:0] standby_limit = 32'h00000014; // Short interval for sim
	logic        spin_req_r;            // Spindle request
	logic        power_idle_r;          // Idle mode flag
	logic [15:0] id_heads_word_r;       // Identify heads word
	logic [15:0] id_spt_word_r;         // Identify sectors word
	int          fail_count = 0;        // Mismatches
	int          samples_checked = 0;   // Comparisons
	int          done_seen = 0;         // Completion pulses counted
	int          n0;                    // Pulse count before a command
	logic [15:0] rd_v;                  // Last read value
	// Geometry row: inputs beside the identify words they should give
	typedef struct packed {
		logic [7:0]  spt;
		logic [3:0]  hd;
		logic [15:0] eh;
		logic [15:0] es;
	} geo_row_t;
	geo_row_t rows [3] = '{
		'{8'h00, 4'h0, 16'h0001, 16'h0000},
		'{8'hFF, 4'hF, 16'h0010, 16'h00FF},
		'{8'h11, 4'h5, 16'h0006, 16'h0011}};

	// ============================================================
	// Clock and pulse counting
	always #2.5 sys_clk = ~sys_clk;
	// Counting pulses lets a double completion show up as a wrong count
	always @(posedge sys_clk) if (cmd_done_r === 1'b1) done_seen++;

	ata_cmd_core ata_cmd_core_inst (.sys_clk(sys_clk), .rst_n(rst_n), .tf_req(tf_req),
		.tf_rdata_r(tf_rdata_r), .cmd_done_r(cmd_done_r), .buf_wr(buf_wr),
		.buf_waddr(buf_waddr), .buf_wdata(buf_wdata), .media_at_speed(media_at_speed),
		.soft_reset(soft_reset), .feature_reset_sel(feature_reset_sel),
		.standby_en(standby_en), .standby_limit(standby_limit), .spin_req_r(spin_req_r),
		.power_idle_r(power_idle_r), .id_heads_word_r(id_heads_word_r),
		.id_spt_word_r(id_spt_word_r));
	host_model host_model_inst (.sys_clk(sys_clk), .tf_rdata_r(tf_rdata_r), .tf_req(tf_req));

	// ============================================================
	// Helpers
	task automatic final_report();
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : final_report

	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		samples_checked++;
		if (g !== e) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// Let edges pass, then sample after the updates settle
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : tick

	// Register read; control registers are eight bits wide
	task automatic rd_chk(input string nm, input logic [2:0] a, input logic [7:0] e);
		host_model_inst.tf_read(a, rd_v);
		chk(nm, {8'h00, e}, {8'h00, rd_v[7:0]});
	endtask : rd_chk

	task automatic cmd(input logic [7:0] op);
		host_model_inst.tf_write(`TF_STATUS, {8'h00, op});
	endtask : cmd

	// Bounded wait for one more completion pulse than before
	task automatic wait_done();
		for (int i = 0; i < 2000; i++) begin
			tick(1);
			if (done_seen > n0) return;
		end
		$display("MISMATCH completion expected pulse seen none");
		fail_count++;
		final_report();
	endtask : wait_done

	// Bounded poll of the status word for a data request
	task automatic wait_drq();
		for (int i = 0; i < 100; i++) begin
			host_model_inst.tf_read(`TF_STATUS, rd_v);
			if (rd_v[`ST_DRQ] === 1'b1) return;
		end
		$display("MISMATCH data request expected 1 seen 0");
		fail_count++;
		final_report();
	endtask : wait_drq

	// ============================================================
	// Main sequence
	initial begin
		tick(4);
		@(posedge sys_clk);
		rst_n <= 1'b1;
		tick(2);
		chk("reset heads", 16'h0010, id_heads_word_r);
		chk("reset spt", 16'h003F, id_spt_word_r);
		$display("test reset done");
		// Geometry table, one geometry command per row
		foreach (rows[i]) begin
			n0 = done_seen;
			host_model_inst.tf_write(`TF_SECCNT, {8'h00, rows[i].spt});
			host_model_inst.tf_write(`TF_DEVHEAD, {8'h00, 4'hA, rows[i].hd});
			cmd(`OPC_INIT_PARAM);
			wait_done();
			tick(3);
			chk("heads word", rows[i].eh, id_heads_word_r);
			chk("spt word", rows[i].es, id_spt_word_r);
			chk("done count", 16'(n0 + 1), 16'(done_seen));
			rd_chk("status", `TF_STATUS, 8'h40);
			rd_chk("error", `TF_ERROR, 8'h00);
		end
		$display("test geometry rows done");
		// Unknown opcode, then read buffer with nothing written
		n0 = done_seen;
		cmd(8'h00);
		wait_done();
		rd_chk("abort error", `TF_ERROR, 8'h04);
		rd_chk("abort status", `TF_STATUS, 8'h41);
		n0 = done_seen;
		cmd(`OPC_READ_BUF);
		wait_done();
		rd_chk("empty buffer error", `TF_ERROR, 8'h04);
		$display("test abort done");
		// Idle from a stopped spindle waits for speed
		n0 = done_seen;
		cmd(`OPC_IDLE_IMM);
		tick(5);
		chk("spin request", 16'h0001, {15'h0000, spin_req_r});
		chk("early done", 16'(n0), 16'(done_seen));
		@(posedge sys_clk);
		media_at_speed <= 1'b1;
		wait_done();
		tick(2);
		chk("idle mode", 16'h0001, {15'h0000, power_idle_r});
		rd_chk("idle status", `TF_STATUS, 8'h50);
		// Already spinning: alternate opcode completes at once
		n0 = done_seen;
		cmd(`OPC_IDLE_IMM_ALT);
		tick(3);
		chk("spinning done", 16'(n0 + 1), 16'(done_seen));
		n0 = done_seen;
		host_model_inst.tf_write(`TF_SECCNT, 16'h0020);
		host_model_inst.tf_write(`TF_DEVHEAD, 16'h00A3);
		cmd(`OPC_INIT_PARAM);
		tick(3);
		chk("next command done", 16'(n0 + 1), 16'(done_seen));
		chk("heads word", 16'h0004, id_heads_word_r);
		$display("test idle done");
		// Timer interval must survive an idle command with a count written
		standby_en <= 1'b1;
		host_model_inst.tf_write(`TF_SECCNT, 16'h0001);
		cmd(`OPC_IDLE_IMM);
		for (int i = 0; i < 5; i++) begin
			tick(10);
			rd_chk("status", `TF_STATUS, 8'h50);
		end
		chk("idle kept by access", 16'h0001, {15'h0000, power_idle_r});
		tick(40);
		chk("standby entered", 16'h0000, {15'h0000, power_idle_r});
		chk("spin released", 16'h0000, {15'h0000, spin_req_r});
		standby_en <= 1'b0;
		$display("test standby done");
		// Fill one sector, then read it back word by word
		for (int i = 0; i < 256; i++) begin
			@(posedge sys_clk);
			buf_wr <= 1'b1;
			buf_waddr <= 8'(i);
			buf_wdata <= {8'(i) ^ 8'hC3, 8'(i)};
		end
		@(posedge sys_clk);
		buf_wr <= 1'b0;
		n0 = done_seen;
		cmd(`OPC_READ_BUF);
		for (int i = 0; i < 256; i++) begin
			wait_drq();
			host_model_inst.tf_read(`TF_DATA, rd_v);
			chk("buffer word", {8'(i) ^ 8'hC3, 8'(i)}, rd_v);
		end
		wait_done();
		host_model_inst.tf_read(`TF_DATA, rd_v);
		chk("word past sector", 16'h0000, rd_v);
		chk("buffer done", 16'(n0 + 1), 16'(done_seen));
		$display("test read buffer done");
		// Soft reset keeps geometry unless defaults are selected
		for (int k = 0; k < 2; k++) begin
			feature_reset_sel <= (k == 0) ? 8'h66 : `FEAT_DEFAULTS;
			@(posedge sys_clk);
			soft_reset <= 1'b1;
			@(posedge sys_clk);
			soft_reset <= 1'b0;
			tick(3);
			chk("heads after soft reset", (k == 0) ? 16'h0004 : 16'h0010, id_heads_word_r);
		end
		chk("spt after defaults", 16'h003F, id_spt_word_r);
		$display("test soft reset done");
		final_report();
	end
endmodule : ata_idle_geometry_buffer_cmds_tb_top
`default_nettype wire
